//--- snand_host.sv
// Purpose: Host model driving the serial link of the sequencer
// Assumes: Mode 0, 30 ns link clock that stands still between frames
// Notes: Idle lanes show the inverse of their last value, except after a getf feature read
`timescale 1ns/100ps
module snand_host (
    output logic SCK,
    output logic CS_N,
    output logic [3:0] LANES,
    input wire logic SO
);
    initial begin
        SCK = 1'b0;
        CS_N = 1'b1;
        LANES = 4'h0;
    end
    // One link clock; lanes change only while it is low
    task automatic clk(input logic [3:0] v, input bit quad);
        LANES = quad ? v : {LANES[3:1], v[0]};
        #15 SCK = 1'b1;
        #15 SCK = 1'b0;
    endtask
    task automatic bits(input logic [23:0] v, input int n);
        for (int i = n - 1; i >= 0; i--) begin
            clk({3'h0, v[i]}, 1'b0);
        end
    endtask
    // Opcode, n argument bits, then data bytes keyed by column
    task automatic frame(input logic [7:0] op, input int n, input logic [23:0] arg,
        input int nd = 0, input logic [7:0] key = 8'h00, input bit quad = 1'b0);
        logic [7:0] d;
        CS_N = 1'b0;
        #15 bits({16'h0, op}, 8);
        bits(arg, n);
        for (int i = 0; i < nd; i++) begin
            d = 8'(arg[11:0] + i) ^ key;
            if (quad) begin
                clk(d[7:4], 1'b1);
                clk(d[3:0], 1'b1);
            end else begin
                bits({16'h0, d}, 8);
            end
        end
        #15 CS_N = 1'b1;
        LANES = ~LANES;
        #300; // Frame ends kept at least six array clocks apart
    endtask
    // Feature read at address fa; sampled just before each rising edge
    task automatic getf(input logic [7:0] fa, output logic [7:0] v);
        CS_N = 1'b0;
        #15 bits({8'h0, snand_pkg::OP_GET_FEATURE, fa}, 16);
        for (int i = 0; i < 8; i++) begin
            #15 v = {v[6:0], SO};
            SCK = 1'b1;
            #15 SCK = 1'b0;
        end
        #15 CS_N = 1'b1;
        #300;
    endtask
endmodule

//--- snand_pkg.sv
// Purpose: Shared constants for the serial NAND program/erase/reset sequencer
// Assumes: Host link in SPI mode 0, commands in single-lane form, data x1 or x4
// Notes: Busy and recovery times are given in microseconds and converted below
package snand_pkg;
    // ********************************
    // Opcodes
    // ********************************
    localparam logic [7:0] OP_CACHE_LOAD = 8'h02;
    localparam logic [7:0] OP_CACHE_LOAD_X4 = 8'h32;
    localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
    localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
    localparam logic [7:0] OP_ARRAY_COMMIT = 8'h10;
    localparam logic [7:0] OP_PAGE_READ = 8'h13;
    localparam logic [7:0] OP_RANDOM_LOAD = 8'h84;
    localparam logic [7:0] OP_RANDOM_LOAD_X4A = 8'hC4;
    localparam logic [7:0] OP_RANDOM_LOAD_X4B = 8'h34;
    localparam logic [7:0] OP_BLOCK_ERASE = 8'hD8;
    localparam logic [7:0] OP_SOFT_RESET = 8'hFF;
    localparam logic [7:0] OP_RESET_ENABLE = 8'h66;
    localparam logic [7:0] OP_FULL_RESET = 8'h99;
    localparam logic [7:0] OP_GET_FEATURE = 8'h0F;
    localparam logic [7:0] OP_SET_FEATURE = 8'h1F;
    // ********************************
    // Feature addresses and bit positions
    // ********************************
    localparam logic [7:0] FEAT_CONFIG_ADDR = 8'hB0;
    localparam logic [7:0] FEAT_STATUS_ADDR = 8'hC0;
    localparam int QE_BIT = 0;
    localparam int ECC_EN_BIT = 4;
    localparam int OIP_BIT = 0;
    localparam int WEL_BIT = 1;
    localparam logic [7:0] CONFIG_RESET = 8'h10;
    // ********************************
    // Geometry
    // ********************************
    localparam int PAGE_BYTES_RAW = 2176;
    localparam int PAGE_BYTES_ECC = 2112;
    localparam int CACHE_AW = 12;
    localparam int ADDR_BITS = 24;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;
    // ********************************
    // Timing
    // ********************************
    localparam int MCLK_MHZ = 20;
    localparam int PROG_TIME_US = 600;
    localparam int ERASE_TIME_US = 10000;
    localparam int RECOVERY_TIME_US = 100;
    localparam int PROG_CYCLES = PROG_TIME_US * MCLK_MHZ;
    localparam int ERASE_CYCLES = ERASE_TIME_US * MCLK_MHZ;
    localparam int RECOVERY_CYCLES = RECOVERY_TIME_US * MCLK_MHZ;
    localparam int BUSY_CW = 24;
    localparam int PAGE_CW = 18;
endpackage

//--- snand_seq.sv
// What this block does
// - Cache load: opcode, 4 dummy bits, 12-bit column, data; select high ends.
// - Loaded bytes go to a one-page cache; bytes beyond a page are dropped.
// - Page length is 2176 bytes without ECC, 2112 with ECC.
// - Commit without write latch flag set is ignored.
// - Random load and soft reset leave cache contents intact.
// - Commit right after sequential load programs unwritten bytes as all-ones.
// - Commit right after random load programs the whole cache as it stands.
// - Quad cache load uses four lanes, accepted only when quad enable set.
// - Commit: opcode plus 24-bit address, then busy for program time.
// - Status may be polled while busy; next load after completion.
// - Cache contents and written map are kept after commit is accepted.
// - Random load: opcode, dummy, 12-bit column; overwrites from that column.
// - Quad random load uses four lanes, only when quad enable set.
// - Erase needs write latch; 24-bit address; one block; busy for erase time.
// - Soft reset aborts program or erase and returns to idle.
// - Full reset: enable frame then reset frame; aborts and restores defaults.
// - During recovery after full reset every command except get feature is rejected.
// - Page or block interrupted by full reset is flagged invalid.
// - Feature get/set use a one-byte feature address after the opcode.
// - Write latch flag is read-only to feature writes.
//
// Purpose: Command sequencer of a serial NAND device: load, commit, erase, reset
// Assumes: SPI mode 0 on SCK, opcode and address on lane zero, MCLK runs the array side
// Notes: Frame decode runs on SCK; finished commands cross to MCLK by a toggle
`timescale 1ns/100ps
module snand_seq #(
    parameter int PROG_CYCLES = snand_pkg::PROG_CYCLES,
    parameter int ERASE_CYCLES = snand_pkg::ERASE_CYCLES,
    parameter int RECOVERY_CYCLES = snand_pkg::RECOVERY_CYCLES
) (
    input wire logic MCLK,
    input wire logic RESET,
    input wire logic SCK,
    input wire logic CS_N,
    input wire logic LANE_ZERO_IN,
    input wire logic LANE_ONE_IN,
    input wire logic LANE_TWO_IN,
    input wire logic LANE_THREE_IN,
    output logic LANE_ONE_OUT,
    output logic LANE_ONE_OE,
    output logic BUSY,
    output logic WRITE_LATCH_FLAG,
    output logic QUAD_INPUT_ENABLE,
    output logic ECC_ENABLE,
    output logic COMMIT_STROBE,
    output logic ERASE_STROBE,
    output logic [23:0] ARRAY_ADDR,
    output logic [7:0] ARRAY_DATA,
    output logic [11:0] ARRAY_COL,
    output logic ARRAY_DATA_VALID,
    output logic TARGET_INVALID
);
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_PROG = 3'b001,
        ST_ERASE = 3'b010,
        ST_RECOVER = 3'b011
    } op_state_e;

    // ********************************
    // Link side (SCK domain)
    // ********************************
    logic [7:0] op_reg;
    logic [5:0] bitcnt_reg;
    logic [31:0] shift_reg;
    logic [7:0] byte_reg;
    logic [2:0] bpos_reg;
    logic [11:0] col_reg;
    logic quad_reg;
    logic [7:0] status_byte;
    logic [7:0] feat_sel_reg;
    logic [7:0] tx_reg;
    // Cache and its written map live on SCK since the host writes them
    logic [7:0] cache_mem [0:snand_pkg::PAGE_BYTES_RAW-1];
    logic [snand_pkg::PAGE_BYTES_RAW-1:0] written_reg;
    logic page_limit_hit;
    logic [11:0] page_len;

    // Quad mode sampled from MCLK through two flops
    logic [1:0] qe_sync_reg;
    logic [1:0] ecc_sync_reg;
    logic [1:0] busy_sync_reg;
    logic [1:0] wel_sync_reg;

    // CS high resets frame state; SCK may stop outside frames
    always_ff @(posedge SCK or posedge CS_N) begin
        if (CS_N) begin
            bitcnt_reg <= 6'h00;
            bpos_reg <= 3'h0;
            op_reg <= 8'h00;
        end else begin
            if (bitcnt_reg < 6'h30) begin
                bitcnt_reg <= bitcnt_reg + 6'h01;
            end
            if (bitcnt_reg == 6'h07) begin
                op_reg <= {shift_reg[6:0], LANE_ZERO_IN};
            end
            if (bitcnt_reg >= 6'h18) begin
                bpos_reg <= bpos_reg + (quad_reg ? 3'h4 : 3'h1);
            end
        end
    end

    // Shift register collects opcode and address on lane zero
    // Data bits follow the column at once, from edge 25 of the frame
    always_ff @(posedge SCK) begin
        shift_reg <= {shift_reg[30:0], LANE_ZERO_IN};
        if (bitcnt_reg >= 6'h18) begin
            byte_reg <= quad_reg ?
                {byte_reg[3:0], LANE_THREE_IN, LANE_TWO_IN, LANE_ONE_IN, LANE_ZERO_IN} :
                {byte_reg[6:0], LANE_ZERO_IN};
        end
    end

    always_ff @(posedge SCK) begin
        qe_sync_reg <= {qe_sync_reg[0], QUAD_INPUT_ENABLE};
        ecc_sync_reg <= {ecc_sync_reg[0], ECC_ENABLE};
        busy_sync_reg <= {busy_sync_reg[0], BUSY};
        wel_sync_reg <= {wel_sync_reg[0], WRITE_LATCH_FLAG};
    end

    // Quad data only when quad enable is set
    assign quad_reg = qe_sync_reg[1] && ((op_reg == snand_pkg::OP_CACHE_LOAD_X4) ||
        (op_reg == snand_pkg::OP_RANDOM_LOAD_X4A) ||
        (op_reg == snand_pkg::OP_RANDOM_LOAD_X4B));

    logic is_load;
    logic is_seq_load;
    logic byte_done;
    assign is_seq_load = (op_reg == snand_pkg::OP_CACHE_LOAD) ||
        (quad_reg && op_reg == snand_pkg::OP_CACHE_LOAD_X4);
    assign is_load = is_seq_load || (op_reg == snand_pkg::OP_RANDOM_LOAD) || (quad_reg &&
        (op_reg == snand_pkg::OP_RANDOM_LOAD_X4A || op_reg == snand_pkg::OP_RANDOM_LOAD_X4B));
    assign page_len = ecc_sync_reg[1] ? 12'(snand_pkg::PAGE_BYTES_ECC) :
        12'(snand_pkg::PAGE_BYTES_RAW);
    assign page_limit_hit = col_reg >= page_len;
    assign byte_done = (bitcnt_reg >= 6'h18) &&
        (quad_reg ? bpos_reg[2] : (bpos_reg == 3'h7));

    // Column pointer: 12-bit column after four dummy bits
    // Column lands on edge 24: opcode 8, dummy 4, column 12
    always_ff @(posedge SCK) begin
        if (bitcnt_reg == 6'h17) begin
            col_reg <= {shift_reg[10:0], LANE_ZERO_IN};
        end else if (byte_done && !page_limit_hit) begin
            col_reg <= col_reg + 12'h001;
        end
    end

    // Cache write, excess bytes dropped; not cleared by random load or reset
    always_ff @(posedge SCK) begin
        if (is_load && byte_done && !page_limit_hit && !busy_sync_reg[1]) begin
            cache_mem[col_reg] <= quad_reg ?
                {byte_reg[3:0], LANE_THREE_IN, LANE_TWO_IN, LANE_ONE_IN, LANE_ZERO_IN} :
                {byte_reg[6:0], LANE_ZERO_IN};
        end
    end

    // Written map: a sequential load starts a fresh map, random load marks every byte written
    always_ff @(posedge SCK) begin
        if (is_seq_load && bitcnt_reg == 6'h17 && !busy_sync_reg[1]) begin
            written_reg <= '0;
        end else if (!is_seq_load && bitcnt_reg == 6'h17 && !busy_sync_reg[1] &&
            (op_reg == snand_pkg::OP_RANDOM_LOAD || quad_reg)) begin
            written_reg <= '1;
        end else if (is_load && byte_done && !page_limit_hit && !busy_sync_reg[1]) begin
            written_reg[col_reg] <= 1'b1;
        end
    end

    // Feature address byte for get feature; set feature takes its address from evt_addr_reg[15:8]
    always_ff @(posedge SCK) begin
        if (bitcnt_reg == 6'h0F) begin
            feat_sel_reg <= {shift_reg[6:0], LANE_ZERO_IN};
        end
    end

    assign status_byte = {6'h00, wel_sync_reg[1], busy_sync_reg[1]};
    // Answer on falling edge so the host samples it on the rising edge
    always_ff @(negedge SCK) begin
        if (bitcnt_reg == 6'h10) begin
            tx_reg <= (feat_sel_reg == snand_pkg::FEAT_STATUS_ADDR) ? status_byte :
                (feat_sel_reg == snand_pkg::FEAT_CONFIG_ADDR) ?
                {3'h0, ecc_sync_reg[1], 3'h0, qe_sync_reg[1]} : 8'h00;
        end else begin
            tx_reg <= {tx_reg[6:0], 1'b0};
        end
    end
    assign LANE_ONE_OUT = tx_reg[7];
    assign LANE_ONE_OE = !CS_N && (op_reg == snand_pkg::OP_GET_FEATURE) &&
        (bitcnt_reg >= 6'h10) && (bitcnt_reg < 6'h18);

    // Frame end: latch command and address, flip a toggle for MCLK
    logic evt_tgl_reg;
    logic [7:0] evt_op_reg;
    logic [23:0] evt_addr_reg;
    logic [7:0] evt_data_reg;
    always_ff @(posedge CS_N) begin
        evt_op_reg <= op_reg;
        evt_addr_reg <= shift_reg[23:0];
        evt_data_reg <= shift_reg[7:0];
    end

    // Toggle cleared with the array side, so both ends of the crossing agree after reset
    always_ff @(posedge CS_N or posedge RESET) begin
        if (RESET) begin
            evt_tgl_reg <= 1'b0;
        end else begin
            evt_tgl_reg <= !evt_tgl_reg;
        end
    end

    // ********************************
    // Array side (MCLK domain)
    // ********************************
    logic [2:0] tgl_sync_reg;
    logic evt_pulse;
    op_state_e state_reg;
    logic [snand_pkg::BUSY_CW-1:0] busy_cnt_reg;
    logic reset_armed_reg;
    logic wel_reg;
    logic [7:0] config_reg;
    logic [snand_pkg::PAGE_CW-1:0] dump_cnt_reg;
    logic last_seq_reg;

    // Toggle crossing; third flop makes the edge
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            tgl_sync_reg <= 3'h0;
        end else begin
            tgl_sync_reg <= {tgl_sync_reg[1:0], evt_tgl_reg};
        end
    end
    assign evt_pulse = tgl_sync_reg[2] ^ tgl_sync_reg[1];

    logic accept;
    assign accept = evt_pulse && state_reg != ST_RECOVER;

    // Operation state machine
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            state_reg <= ST_IDLE;
            busy_cnt_reg <= '0;
            reset_armed_reg <= 1'b0;
            TARGET_INVALID <= 1'b0;
            ARRAY_ADDR <= 24'h000000;
            COMMIT_STROBE <= 1'b0;
            ERASE_STROBE <= 1'b0;
        end else begin
            COMMIT_STROBE <= 1'b0;
            ERASE_STROBE <= 1'b0;
            if (accept) begin
                reset_armed_reg <= (evt_op_reg == snand_pkg::OP_RESET_ENABLE);
            end
            if (accept && evt_op_reg == snand_pkg::OP_FULL_RESET && reset_armed_reg) begin
                TARGET_INVALID <= (state_reg != ST_IDLE);
                state_reg <= ST_RECOVER;
                busy_cnt_reg <= snand_pkg::BUSY_CW'(RECOVERY_CYCLES);
            end else if (accept && evt_op_reg == snand_pkg::OP_SOFT_RESET) begin
                state_reg <= ST_IDLE;
                busy_cnt_reg <= '0;
            end else begin
                case (state_reg)
                    ST_IDLE: begin
                        if (accept && wel_reg && evt_op_reg == snand_pkg::OP_ARRAY_COMMIT) begin
                            state_reg <= ST_PROG;
                            ARRAY_ADDR <= evt_addr_reg;
                            COMMIT_STROBE <= 1'b1;
                            busy_cnt_reg <= snand_pkg::BUSY_CW'(PROG_CYCLES);
                        end else if (accept && wel_reg &&
                            evt_op_reg == snand_pkg::OP_BLOCK_ERASE) begin
                            state_reg <= ST_ERASE;
                            ARRAY_ADDR <= evt_addr_reg;
                            ERASE_STROBE <= 1'b1;
                            busy_cnt_reg <= snand_pkg::BUSY_CW'(ERASE_CYCLES);
                        end
                    end
                    ST_PROG, ST_ERASE, ST_RECOVER: begin
                        if (busy_cnt_reg <= 1) begin
                            state_reg <= ST_IDLE;
                            busy_cnt_reg <= '0;
                        end else begin
                            busy_cnt_reg <= busy_cnt_reg - 1'b1;
                        end
                    end
                    default: state_reg <= ST_IDLE;
                endcase
            end
        end
    end
    assign BUSY = state_reg != ST_IDLE;

    // Write latch: only write enable sets it; finish, write disable and recovery clear it; set wins
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            wel_reg <= 1'b0;
        end else if (accept && evt_op_reg == snand_pkg::OP_WRITE_ENABLE) begin
            wel_reg <= 1'b1;
        end else if (state_reg == ST_RECOVER ||
            (accept && evt_op_reg == snand_pkg::OP_WRITE_DISABLE) ||
            ((state_reg == ST_PROG || state_reg == ST_ERASE) && busy_cnt_reg <= 1)) begin
            wel_reg <= 1'b0;
        end
    end
    assign WRITE_LATCH_FLAG = wel_reg;

    // Config register; defaults return on full reset, soft reset keeps them
    always_ff @(posedge MCLK) begin
        if (RESET || state_reg == ST_RECOVER) begin
            config_reg <= snand_pkg::CONFIG_RESET;
        end else if (accept && evt_op_reg == snand_pkg::OP_SET_FEATURE &&
            evt_addr_reg[15:8] == snand_pkg::FEAT_CONFIG_ADDR) begin
            config_reg <= evt_data_reg;
        end
    end
    assign QUAD_INPUT_ENABLE = config_reg[snand_pkg::QE_BIT];
    assign ECC_ENABLE = config_reg[snand_pkg::ECC_EN_BIT];

    // Cache stream to array during program; unwritten bytes read 0xFF
    always_ff @(posedge MCLK) begin
        // Soft reset drops the stream in the same cycle as busy
        if (RESET || state_reg != ST_PROG ||
            (accept && evt_op_reg == snand_pkg::OP_SOFT_RESET)) begin
            dump_cnt_reg <= '0;
            ARRAY_DATA_VALID <= 1'b0;
            ARRAY_DATA <= 8'h00;
            ARRAY_COL <= 12'h000;
        end else if (dump_cnt_reg < snand_pkg::PAGE_CW'(snand_pkg::PAGE_BYTES_RAW)) begin
            dump_cnt_reg <= dump_cnt_reg + 1'b1;
            ARRAY_COL <= dump_cnt_reg[11:0];
            ARRAY_DATA <= written_reg[dump_cnt_reg[11:0]] ? cache_mem[dump_cnt_reg[11:0]] :
                snand_pkg::ERASED_BYTE;
            ARRAY_DATA_VALID <= 1'b1;
        end else begin
            ARRAY_DATA_VALID <= 1'b0;
        end
    end
endmodule

//--- snand_seq_checker.sv
// Purpose: Concurrent checks on the sequencer's array-side outputs
// Assumes: All watched signals belong to the MCLK domain
// Notes: Link-side inputs are judged by the bench, not here
`timescale 1ns/100ps
module snand_seq_checker (
    input wire logic MCLK,
    input wire logic RESET,
    input wire logic BUSY,
    input wire logic WRITE_LATCH_FLAG,
    input wire logic QUAD_INPUT_ENABLE,
    input wire logic ECC_ENABLE,
    input wire logic COMMIT_STROBE,
    input wire logic ERASE_STROBE,
    input wire logic [23:0] ARRAY_ADDR,
    input wire logic [11:0] ARRAY_COL,
    input wire logic ARRAY_DATA_VALID,
    input wire logic TARGET_INVALID
);
    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (RESET);
    // Row must not move for eight clocks once the transfer is under way
    sequence s_addr_held;
        $stable(ARRAY_ADDR) [*8];
    endsequence
    // An erase moves no page data
    sequence s_no_stream;
        !ARRAY_DATA_VALID [*8];
    endsequence
    a_commit_latch: assert property (COMMIT_STROBE |-> WRITE_LATCH_FLAG)
        else $error("commit started with latch clear");
    a_erase_latch: assert property (ERASE_STROBE |-> WRITE_LATCH_FLAG)
        else $error("erase started with latch clear");
    a_commit_busy: assert property (COMMIT_STROBE |-> ##[0:4] BUSY)
        else $error("commit did not raise busy");
    a_addr_held: assert property (COMMIT_STROBE |=> ##1 s_addr_held)
        else $error("row address moved during commit");
    a_erase_quiet: assert property (ERASE_STROBE |=> s_no_stream)
        else $error("data streamed during erase");
    a_stream_busy: assert property (ARRAY_DATA_VALID |-> BUSY && ARRAY_COL < 12'h880)
        else $error("beat outside busy or past page");
    a_col_step: assert property (ARRAY_DATA_VALID && $past(ARRAY_DATA_VALID)
        |-> ARRAY_COL == $past(ARRAY_COL) + 12'h001)
        else $error("column did not step by one");
    a_full_defaults: assert property ($rose(TARGET_INVALID)
        |-> ##[0:4] (BUSY && !QUAD_INPUT_ENABLE && ECC_ENABLE))
        else $error("full reset left config or busy wrong");
endmodule

//--- tb_top.sv
// Purpose: Self-checking bench for the program, erase and reset sequencer
// Assumes: Short busy counts; one stream beat per array clock
// Notes: Page images are rebuilt here from the load keys
`timescale 1ns/100ps
module tb_top;
    localparam int PROG_N = 2500;
    localparam int ERASE_N = 80;
    localparam int RECOV_N = 120;
    logic MCLK = 1'b0;
    logic RESET = 1'b1;
    logic sck, cs_n, so_out, so_oe, busy, write_latch_flag, qe, ecc, c_stb, e_stb, dv, inval;
    logic [3:0] lanes;
    logic [23:0] addr;
    logic [11:0] col;
    logic [7:0] data, rd;
    logic [8:0] img [0:4095];
    int err_total = 0;
    int total_checks = 0;
    int beats = 0;
    wire lane_one = so_oe ? so_out : lanes[1];
    always #25 MCLK = ~MCLK;
    snand_host host_u (.SCK(sck), .CS_N(cs_n), .LANES(lanes), .SO(lane_one));
    snand_seq #(.PROG_CYCLES(PROG_N), .ERASE_CYCLES(ERASE_N), .RECOVERY_CYCLES(RECOV_N)) dut_u (
        .MCLK(MCLK), .RESET(RESET), .SCK(sck), .CS_N(cs_n), .LANE_ZERO_IN(lanes[0]),
        .LANE_ONE_IN(lane_one), .LANE_TWO_IN(lanes[2]), .LANE_THREE_IN(lanes[3]),
        .LANE_ONE_OUT(so_out), .LANE_ONE_OE(so_oe), .BUSY(busy), .WRITE_LATCH_FLAG(write_latch_flag),
        .QUAD_INPUT_ENABLE(qe), .ECC_ENABLE(ecc), .COMMIT_STROBE(c_stb), .ERASE_STROBE(e_stb),
        .ARRAY_ADDR(addr), .ARRAY_DATA(data), .ARRAY_COL(col), .ARRAY_DATA_VALID(dv),
        .TARGET_INVALID(inval));
    task automatic check(input string nm, input logic [23:0] e, input logic [23:0] g);
        total_checks++;
        if (g !== e) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic complete_run();
        if (err_total == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // Each committed beat against the page image, where its image byte is marked
    always @(posedge MCLK) begin
        if (dv === 1'b1) begin
            beats++;
            if (img[col][8] === 1'b1) begin
                check("array data", {16'h0, img[col][7:0]}, {16'h0, data});
            end
        end
    end
    task automatic idle(input int n);
        repeat (n) @(negedge MCLK);
    endtask
    task automatic wait_busy(input logic lvl, input int lim);
        for (int n = 0; n < lim && busy !== lvl; n++) begin
            idle(1);
        end
        check("busy", {23'h0, lvl}, {23'h0, busy});
    endtask
    task automatic paint(input int c0, input int n, input logic [8:0] key);
        for (int c = c0; c < c0 + n; c++) begin
            img[c] = {key[8], 8'(c) ^ key[7:0]};
        end
    endtask
    // Constant expectation, for bytes that no load has touched
    task automatic fill(input int c0, input int n, input logic [8:0] v);
        for (int c = c0; c < c0 + n; c++) begin
            img[c] = v;
        end
    endtask
    task automatic wen();
        host_u.frame(snand_pkg::OP_WRITE_ENABLE, 0, 24'h0);
        idle(6);
    endtask
    // Full program pass with a status poll while busy
    task automatic commit(input logic [23:0] ra);
        beats = 0;
        wen();
        check("latch", 24'h1, {23'h0, write_latch_flag});
        host_u.frame(snand_pkg::OP_ARRAY_COMMIT, 24, ra);
        wait_busy(1'b1, 20);
        check("row", ra, addr);
        host_u.getf(snand_pkg::FEAT_STATUS_ADDR, rd);
        check("status", 24'h3, {22'h0, rd[1:0]});
        wait_busy(1'b0, PROG_N + 500);
        check("beats", 24'(snand_pkg::PAGE_BYTES_RAW), 24'(beats));
        check("latch clear", 24'h0, {23'h0, write_latch_flag});
    endtask
    initial begin
        #2000000;
        err_total++;
        complete_run();
    end
    initial begin
        paint(0, 4096, 9'h000);
        idle(20);
        RESET = 1'b0;
        idle(4);
        check("reset state", 24'h1, {20'h0, busy, write_latch_flag, qe, ecc});
        // Commit with the latch clear is dropped
        host_u.frame(snand_pkg::OP_CACHE_LOAD, 16, 24'h0, 1);
        host_u.frame(snand_pkg::OP_ARRAY_COMMIT, 24, 24'h000100);
        idle(10);
        check("no latch", 24'h0, {23'h0, busy});
        // Tail past the ECC page, then a quad load while quad is off
        host_u.frame(snand_pkg::OP_CACHE_LOAD, 16, 24'd2100, 20, 8'h55);
        host_u.frame(snand_pkg::OP_CACHE_LOAD_X4, 16, 24'h0, 4, 8'h66, 1'b1);
        fill(0, 4096, {1'b1, snand_pkg::ERASED_BYTE});
        paint(2100, 12, 9'h155);
        commit(24'h000140);
        host_u.frame(snand_pkg::OP_SET_FEATURE, 16, {8'h0, snand_pkg::FEAT_CONFIG_ADDR, 8'h01});
        idle(6);
        check("config", 24'h2, {22'h0, qe, ecc});
        host_u.getf(snand_pkg::FEAT_CONFIG_ADDR, rd);
        check("config read", 24'h01, {16'h0, rd});
        // Quad load, soft reset, then random loads of every kind
        host_u.frame(snand_pkg::OP_CACHE_LOAD_X4, 16, 24'h0, 4, 8'h11, 1'b1);
        host_u.frame(snand_pkg::OP_SOFT_RESET, 0, 24'h0);
        host_u.frame(snand_pkg::OP_RANDOM_LOAD_X4B, 16, 24'h2, 2, 8'h22, 1'b1);
        host_u.frame(snand_pkg::OP_RANDOM_LOAD_X4A, 16, 24'h8, 1, 8'h33, 1'b1);
        host_u.frame(snand_pkg::OP_RANDOM_LOAD, 16, 24'h9, 1, 8'h44);
        paint(0, 4096, 9'h000);
        paint(0, 2, 9'h111);
        paint(2, 2, 9'h122);
        paint(8, 1, 9'h133);
        paint(9, 1, 9'h144);
        commit(24'h000141);
        // Erase refused, erase done, erase aborted by soft reset
        host_u.frame(snand_pkg::OP_BLOCK_ERASE, 24, 24'h000200);
        idle(10);
        check("erase no latch", 24'h0, {23'h0, busy});
        wen();
        host_u.frame(snand_pkg::OP_BLOCK_ERASE, 24, 24'h000200);
        wait_busy(1'b1, 20);
        check("erase row", 24'h000200, addr);
        wait_busy(1'b0, ERASE_N + 20);
        check("erase latch", 24'h0, {23'h0, write_latch_flag});
        wen();
        host_u.frame(snand_pkg::OP_BLOCK_ERASE, 24, 24'h000240);
        wait_busy(1'b1, 20);
        host_u.frame(snand_pkg::OP_SOFT_RESET, 0, 24'h0);
        wait_busy(1'b0, 10);
        check("soft keeps config", 24'h2, {22'h0, qe, ecc});
        // Full reset across a running program
        wen();
        host_u.frame(snand_pkg::OP_ARRAY_COMMIT, 24, 24'h000142);
        wait_busy(1'b1, 20);
        host_u.frame(snand_pkg::OP_RESET_ENABLE, 0, 24'h0);
        host_u.frame(snand_pkg::OP_FULL_RESET, 0, 24'h0);
        idle(6);
        check("full reset", 24'hD, {20'h0, busy, inval, qe, ecc});
        wen();
        check("recovery refuse", 24'h0, {23'h0, write_latch_flag});
        // A soft reset sent here is refused and recovery goes on
        host_u.frame(snand_pkg::OP_SOFT_RESET, 0, 24'h0);
        check("recovery busy", 24'h1, {23'h0, busy});
        wait_busy(1'b0, RECOV_N + 20);
        host_u.frame(snand_pkg::OP_SET_FEATURE, 16, {8'h0, snand_pkg::FEAT_STATUS_ADDR, 8'h02});
        idle(6);
        check("latch read only", 24'h0, {23'h0, write_latch_flag});
        wen();
        check("latch after", 24'h1, {23'h0, write_latch_flag});
        host_u.frame(snand_pkg::OP_WRITE_DISABLE, 0, 24'h0);
        idle(6);
        check("latch off", 24'h0, {23'h0, write_latch_flag});
        complete_run();
    end
endmodule
bind snand_seq snand_seq_checker chk_u (.MCLK(MCLK), .RESET(RESET), .BUSY(BUSY),
    .WRITE_LATCH_FLAG(WRITE_LATCH_FLAG), .QUAD_INPUT_ENABLE(QUAD_INPUT_ENABLE),
    .ECC_ENABLE(ECC_ENABLE), .COMMIT_STROBE(COMMIT_STROBE), .ERASE_STROBE(ERASE_STROBE),
    .ARRAY_ADDR(ARRAY_ADDR), .ARRAY_COL(ARRAY_COL), .ARRAY_DATA_VALID(ARRAY_DATA_VALID),
    .TARGET_INVALID(TARGET_INVALID));
